// >>> src/cie_defines.vh
// Purpose: Shared constants of the instruction subset execution core.
// Assumes: Byte addresses on an 8-bit Wishbone address; 32-bit data.
// Notes: Field macros are bit ranges used as cmd_q[`CIE_F_xx].
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH
`define CIE_A_CMD 8'h40
`define CIE_A_ARG 8'h44
`define CIE_A_FREG 8'h48
`define CIE_A_STAT 8'h4c
`define CIE_A_PC 8'h50
`define CIE_A_LCNT 8'h54
`define CIE_A_LEND 8'h58
`define CIE_A_ACAL 8'h5c
`define CIE_A_ACAH 8'h60
`define CIE_A_ACBL 8'h64
`define CIE_A_ACBH 8'h68
`define CIE_F_OP 4:0
`define CIE_F_RS 8:5
`define CIE_F_RD 12:9
`define CIE_F_ACC 13
`define CIE_F_XM 17:14
`define CIE_F_YM 21:18
`define CIE_F_XD 23:22
`define CIE_F_FM 25:24
`define CIE_F_LIT 13:0
`define CIE_F_OFS 31:16
`define CIE_OP_QS16 5'h00
`define CIE_OP_QS32 5'h01
`define CIE_OP_QU16 5'h02
`define CIE_OP_QU32 5'h03
`define CIE_OP_QFR 5'h04
`define CIE_OP_LOOPL 5'h05
`define CIE_OP_LOOPW 5'h06
`define CIE_OP_EUC 5'h07
`define CIE_OP_EUCA 5'h08
`define CIE_OP_SWAP 5'h09
`define CIE_OP_BCHG 5'h0a
`define CIE_OP_F1L 5'h0b
`define CIE_OP_F1R 5'h0c
`define CIE_OP_JMPD 5'h0d
`define CIE_OP_JMPI 5'h0e
`define CIE_OP_ADD1 5'h0f
`define CIE_OP_ADD2 5'h10
`define CIE_OP_OR 5'h11
`define CIE_QUO_CYC 5'h12
`define CIE_LOOP_CYC 5'h02
`define CIE_JMP_CYC 5'h02
`define CIE_ONE_CYC 5'h01
`define CIE_FM_W 2'h0
`define CIE_FM_F 2'h1
`define CIE_FM_DEFAULT_WORKING_REG 2'h2
`define CIE_S_C 0
`define CIE_S_Z 1
`define CIE_S_OV 2
`define CIE_S_N 3
`define CIE_S_DC 4
`define CIE_S_OA 8
`define CIE_S_OB 9
`define CIE_S_OAB 10
`define CIE_S_SA 11
`define CIE_S_SB 12
`define CIE_S_SAB 13
`define CIE_S_ERR 14
`define CIE_DEFAULT_WORKING_REG 4'h0
`define CIE_DSP_LO 4'h4
`define CIE_X0 4'h8
`define CIE_X1 4'h9
`define CIE_Y0 4'ha
`define CIE_Y1 4'hb
`define CIE_PFO 4'hc
`define CIE_PF_IDX 4'he
`define CIE_PF_NONE 4'hf
`define CIE_RST16 16'h0000
`define CIE_SAT_POS 40'h7fffffffff
`define CIE_SAT_NEG 40'h8000000000
`endif

// >>> src/cie_core.v
// Purpose: Executes a subset of a 16-bit DSP core's instructions on a
//   working register file, reached over classic Wishbone.
// Assumes: One clock; software issues one command while not busy.
// Notes: Writes to registers are refused while an op is in flight.
// How it works
// - Signed 16/16 integer quotient, one word, 18 cycles, sets N Z C OV.
// - Signed 32/16 integer quotient, one word, 18 cycles, sets N Z C OV.
// - Unsigned 16/16 integer quotient, one word, 18 cycles, sets N Z C OV.
// - Unsigned 32/16 integer quotient, one word, 18 cycles, sets N Z C OV.
// - Signed fractional quotient, one word, 18 cycles, sets N Z C OV.
// - Loop on literal: end PC plus offset, lit plus one times, 2 words.
// - Loop on register: end PC plus offset, Wn plus one times, 2 words.
// - Distance squares into accumulator; accumulating form adds; sets OA/SA or OB/SB by accumulator, and OAB/SAB.
// - Bit-change scan from MSB writes position, touches only carry.
// - First one from MSB writes position, touches only carry.
// - First one from LSB writes position, touches only carry.
// - Squares use one register, W4 to W7 only.
// - Two-operand products use the six distinct pairs of W4 to W7.
// - X prefetch via W8/W9 with +-6/4/2 or none, W9+W12, or off.
// - Y prefetch via W10/W11 with +-6/4/2 or none, W11+W12, or off.
// - Prefetched data lands only in W4 to W7.
// - Default working register of file forms is W0.
// - Register fields select any of W0 to W15.
`timescale 1ns/1ps
`include "cie_defines.vh"
module cie_core #(
   parameter DM_AW = 4
) (
   input wire CORE_CLK,
   input wire RSTN,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   output reg BUSY
);
   localparam DM_DEPTH = 1 << DM_AW;
   integer i;
   integer j;
   reg [15:0] w_q [0:15];
   reg [15:0] dm_q [0:DM_DEPTH-1];
   reg [31:0] cmd_q;
   reg [31:0] arg_q;
   reg [15:0] f_q;
   reg [15:0] st_q;
   reg [15:0] pc_q;
   reg [15:0] lcnt_q;
   reg [15:0] lend_q;
   reg [39:0] acca_q;
   reg [39:0] accb_q;
   reg [4:0] cnt_q;

   wire req = WB_CYC_I & WB_STB_I;
   // Write lands on the edge where the master sees ack
   wire wr = req & WB_WE_I & WB_ACK_O & ~BUSY;
   wire [7:0] ba = {WB_ADR_I[7:2], 2'b00};
   wire [31:0] bm = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   wire [4:0] op = cmd_q[`CIE_F_OP];
   wire [3:0] rs = cmd_q[`CIE_F_RS];
   wire [3:0] rd = cmd_q[`CIE_F_RD];
   wire [3:0] rs1 = rs + 4'h1;
   wire [3:0] xm = cmd_q[`CIE_F_XM];
   wire [3:0] ym = cmd_q[`CIE_F_YM];
   wire [1:0] fm = cmd_q[`CIE_F_FM];
   wire use_acb = cmd_q[`CIE_F_ACC];

   function [15:0] m16(input [15:0] o);
      m16 = (o & ~bm[15:0]) | (WB_DAT_I[15:0] & bm[15:0]);
   endfunction
   function [31:0] m32(input [31:0] o);
      m32 = (o & ~bm) | (WB_DAT_I & bm);
   endfunction
   function [4:0] cyc_of(input [4:0] o);
      if (o <= `CIE_OP_QFR)
         cyc_of = `CIE_QUO_CYC;
      else if (o == `CIE_OP_LOOPL || o == `CIE_OP_LOOPW)
         cyc_of = `CIE_LOOP_CYC;
      else if (o == `CIE_OP_JMPD || o == `CIE_OP_JMPI)
         cyc_of = `CIE_JMP_CYC;
      else
         cyc_of = `CIE_ONE_CYC;
   endfunction
   // Post-modify step of a prefetch mode, repeating every seven codes
   function [15:0] pmod(input [3:0] m);
      case (m)
         4'h0, 4'h7: pmod = 16'h0006;
         4'h1, 4'h8: pmod = 16'h0004;
         4'h2, 4'h9: pmod = 16'h0002;
         4'h4, 4'hb: pmod = 16'hfffa;
         4'h5, 4'hc: pmod = 16'hfffc;
         4'h6, 4'hd: pmod = 16'hfffe;
         default: pmod = 16'h0000;
      endcase
   endfunction
   function ovf(input [39:0] a);
      ovf = ~(&a[39:31] | ~|a[39:31]);
   endfunction

   wire [31:0] cmd_nx = m32(cmd_q);

   // Divide family
   reg [31:0] dvd, dvs, q, r;
   reg sg, dz, dov;
   always @* begin
      sg = (op == `CIE_OP_QS16) | (op == `CIE_OP_QS32) | (op == `CIE_OP_QFR);
      case (op)
         `CIE_OP_QS32, `CIE_OP_QU32: dvd = {w_q[rs1], w_q[rs]};
         `CIE_OP_QFR: dvd = {w_q[rs][15], w_q[rs], 15'h0000};
         `CIE_OP_QS16: dvd = {{16{w_q[rs][15]}}, w_q[rs]};
         default: dvd = {16'h0000, w_q[rs]};
      endcase
      dz = (w_q[rd] == 16'h0000);
      dvs = dz ? 32'h00000001 : sg ? {{16{w_q[rd][15]}}, w_q[rd]} : {16'h0000, w_q[rd]};
      if (sg) begin
         q = $signed(dvd) / $signed(dvs);
         r = $signed(dvd) % $signed(dvs);
      end else begin
         q = dvd / dvs;
         r = dvd % dvs;
      end
      // Signed quotient fits only while bits 31:15 all copy the sign
      dov = dz | (sg ? ~(&q[31:15] | ~|q[31:15]) : |q[31:16]);
   end

   // Product operands: squares of W4..W7, then the six distinct pairs
   reg [3:0] ma, mb;
   reg pair_ok;
   always @* begin
      pair_ok = 1'b1;
      {ma, mb} = 8'h44;
      case (rs)
         4'h0, 4'h1, 4'h2, 4'h3: {ma, mb} = {`CIE_DSP_LO + rs, `CIE_DSP_LO + rs};
         4'h4: {ma, mb} = 8'h45;
         4'h5: {ma, mb} = 8'h46;
         4'h6: {ma, mb} = 8'h47;
         4'h7: {ma, mb} = 8'h56;
         4'h8: {ma, mb} = 8'h57;
         4'h9: {ma, mb} = 8'h67;
         default: pair_ok = 1'b0;
      endcase
   end

   wire [31:0] prod = $signed(w_q[ma]) * $signed(w_q[mb]);
   wire [39:0] pfr = {{7{prod[31]}}, prod, 1'b0};
   wire [39:0] acc = use_acb ? accb_q : acca_q;
   wire [40:0] asum = (op == `CIE_OP_EUCA) ? {acc[39], acc} + {pfr[39], pfr} : {pfr[39], pfr};
   wire asat = asum[40] ^ asum[39];
   wire [39:0] anew = asat ? (asum[40] ? `CIE_SAT_NEG : `CIE_SAT_POS) : asum[39:0];
   wire oa_n = use_acb ? st_q[`CIE_S_OA] : ovf(anew);
   wire ob_n = use_acb ? ovf(anew) : st_q[`CIE_S_OB];
   wire sa_n = st_q[`CIE_S_SA] | (~use_acb & asat);
   wire sb_n = st_q[`CIE_S_SB] | (use_acb & asat);

   // Prefetch addresses
   wire [15:0] xbase = (xm < 4'h7) ? w_q[`CIE_X0] : w_q[`CIE_X1];
   wire [15:0] xadr = (xm == `CIE_PF_IDX) ? w_q[`CIE_X1] + w_q[`CIE_PFO] : xbase;
   wire [15:0] ybase = (ym < 4'h7) ? w_q[`CIE_Y0] : w_q[`CIE_Y1];
   wire [15:0] yadr = (ym == `CIE_PF_IDX) ? w_q[`CIE_Y1] + w_q[`CIE_PFO] : ybase;
   wire [15:0] xdat = (xm == `CIE_PF_NONE) ? 16'h0000 : dm_q[xadr[DM_AW:1]];
   wire [15:0] ydat = (ym == `CIE_PF_NONE) ? 16'h0000 : dm_q[yadr[DM_AW:1]];
   wire [3:0] xd_idx = {2'b01, cmd_q[`CIE_F_XD]};

   // Scans; carry means nothing was found
   wire [15:0] sv = w_q[rs];
   wire nbc = &sv | ~|sv;
   wire nfl = ~|sv;
   reg [4:0] sbc, sfl, sfr;
   always @* begin
      sbc = 5'h0f;
      sfl = 5'h00;
      sfr = 5'h00;
      for (j = 0; j < 16; j = j + 1) begin
         if (sv[j] != sv[15])
            sbc = 5'h0e - j[4:0];
         if (sv[j])
            sfl = 5'h10 - j[4:0];
         if (sv[15 - j])
            sfr = 5'h10 - j[4:0];
      end
   end

   // Add one/two and OR
   wire [15:0] isrc = (fm == `CIE_FM_W) ? w_q[rs] : f_q;
   wire [16:0] isum = {1'b0, isrc} + {15'h0000, op == `CIE_OP_ADD2, op == `CIE_OP_ADD1};
   wire [4:0] idc = {1'b0, isrc[3:0]} + {3'h0, op == `CIE_OP_ADD2, op == `CIE_OP_ADD1};
   wire [15:0] orv = f_q | w_q[`CIE_DEFAULT_WORKING_REG];
   wire [15:0] nwords = (op == `CIE_OP_LOOPL || op == `CIE_OP_LOOPW || op == `CIE_OP_JMPD) ? 16'h0002 : 16'h0001;

   // Read mux
   reg [31:0] rdat;
   always @* begin
      rdat = 32'h00000000;
      if (ba < `CIE_A_CMD)
         rdat = {16'h0000, w_q[WB_ADR_I[5:2]]};
      else if (ba == `CIE_A_CMD)
         rdat = cmd_q;
      else if (ba == `CIE_A_ARG)
         rdat = arg_q;
      else if (ba == `CIE_A_FREG)
         rdat = {16'h0000, f_q};
      else if (ba == `CIE_A_STAT)
         rdat = {15'h0000, BUSY, st_q};
      else if (ba == `CIE_A_PC)
         rdat = {16'h0000, pc_q};
      else if (ba == `CIE_A_LCNT)
         rdat = {16'h0000, lcnt_q};
      else if (ba == `CIE_A_LEND)
         rdat = {16'h0000, lend_q};
      else if (ba == `CIE_A_ACAL)
         rdat = acca_q[31:0];
      else if (ba == `CIE_A_ACAH)
         rdat = {24'h000000, acca_q[39:32]};
      else if (ba == `CIE_A_ACBL)
         rdat = accb_q[31:0];
      else if (ba == `CIE_A_ACBH)
         rdat = {24'h000000, accb_q[39:32]};
      else if (WB_ADR_I[7])
         rdat = {16'h0000, dm_q[WB_ADR_I[DM_AW+1:2]]};
   end

   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= req & ~WB_ACK_O;
         if (req & ~WB_ACK_O & ~WB_WE_I)
            WB_DAT_O <= rdat;
      end
   end

   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (i = 0; i < 16; i = i + 1)
            w_q[i] <= `CIE_RST16;
         for (i = 0; i < DM_DEPTH; i = i + 1)
            dm_q[i] <= `CIE_RST16;
         cmd_q <= 32'h00000000;
         arg_q <= 32'h00000000;
         f_q <= `CIE_RST16;
         st_q <= `CIE_RST16;
         pc_q <= `CIE_RST16;
         lcnt_q <= `CIE_RST16;
         lend_q <= `CIE_RST16;
         acca_q <= 40'h0000000000;
         accb_q <= 40'h0000000000;
         cnt_q <= 5'h00;
         BUSY <= 1'b0;
      end else if (wr) begin
         if (ba < `CIE_A_CMD)
            w_q[WB_ADR_I[5:2]] <= m16(w_q[WB_ADR_I[5:2]]);
         else if (ba == `CIE_A_CMD) begin
            cmd_q <= cmd_nx;
            cnt_q <= cyc_of(cmd_nx[`CIE_F_OP]) - 5'h01;
            BUSY <= 1'b1;
         end else if (ba == `CIE_A_ARG)
            arg_q <= m32(arg_q);
         else if (ba == `CIE_A_FREG)
            f_q <= m16(f_q);
         else if (ba == `CIE_A_STAT)
            st_q <= m16(st_q);
         else if (ba == `CIE_A_PC)
            pc_q <= m16(pc_q);
         else if (ba == `CIE_A_ACAL)
            acca_q[31:0] <= m32(acca_q[31:0]);
         else if (ba == `CIE_A_ACAH && WB_SEL_I[0])
            acca_q[39:32] <= WB_DAT_I[7:0];
         else if (ba == `CIE_A_ACBL)
            accb_q[31:0] <= m32(accb_q[31:0]);
         else if (ba == `CIE_A_ACBH && WB_SEL_I[0])
            accb_q[39:32] <= WB_DAT_I[7:0];
         else if (WB_ADR_I[7])
            dm_q[WB_ADR_I[DM_AW+1:2]] <= m16(dm_q[WB_ADR_I[DM_AW+1:2]]);
      end else if (BUSY && cnt_q != 5'h00) begin
         cnt_q <= cnt_q - 5'h01;
      end else if (BUSY) begin
         BUSY <= 1'b0;
         pc_q <= pc_q + nwords;
         case (op)
            `CIE_OP_QS16, `CIE_OP_QS32, `CIE_OP_QU16, `CIE_OP_QU32, `CIE_OP_QFR: begin
               // Quotient to W0, remainder to W1
               w_q[0] <= q[15:0];
               w_q[1] <= r[15:0];
               st_q[`CIE_S_N] <= q[15];
               st_q[`CIE_S_Z] <= (q[15:0] == 16'h0000);
               st_q[`CIE_S_C] <= (r[15:0] != 16'h0000);
               st_q[`CIE_S_OV] <= dov;
            end
            `CIE_OP_LOOPL, `CIE_OP_LOOPW: begin
               lcnt_q <= (op == `CIE_OP_LOOPL) ? {2'b00, arg_q[`CIE_F_LIT]} : w_q[rs];
               lend_q <= pc_q + arg_q[`CIE_F_OFS];
            end
            `CIE_OP_EUC, `CIE_OP_EUCA: begin
               if (!pair_ok)
                  st_q[`CIE_S_ERR] <= 1'b1;
               else begin
                  if (use_acb)
                     accb_q <= anew;
                  else
                     acca_q <= anew;
                  st_q[`CIE_S_OA] <= oa_n;
                  st_q[`CIE_S_OB] <= ob_n;
                  st_q[`CIE_S_OAB] <= oa_n | ob_n;
                  st_q[`CIE_S_SA] <= sa_n;
                  st_q[`CIE_S_SB] <= sb_n;
                  st_q[`CIE_S_SAB] <= sa_n | sb_n;
                  if (xm != `CIE_PF_NONE && xm != `CIE_PF_IDX)
                     w_q[(xm < 4'h7) ? `CIE_X0 : `CIE_X1] <= xbase + pmod(xm);
                  if (ym != `CIE_PF_NONE && ym != `CIE_PF_IDX)
                     w_q[(ym < 4'h7) ? `CIE_Y0 : `CIE_Y1] <= ybase + pmod(ym);
                  // Difference of the two fetched words feeds the next square
                  if (xm != `CIE_PF_NONE)
                     w_q[xd_idx] <= xdat - ydat;
               end
            end
            `CIE_OP_SWAP: begin
               w_q[rs] <= w_q[rd];
               w_q[rd] <= w_q[rs];
            end
            `CIE_OP_BCHG: begin
               w_q[rd] <= {11'h000, sbc};
               st_q[`CIE_S_C] <= nbc;
            end
            `CIE_OP_F1L: begin
               w_q[rd] <= {11'h000, sfl};
               st_q[`CIE_S_C] <= nfl;
            end
            `CIE_OP_F1R: begin
               w_q[rd] <= {11'h000, sfr};
               st_q[`CIE_S_C] <= nfl;
            end
            `CIE_OP_JMPD: pc_q <= arg_q[`CIE_F_OFS];
            `CIE_OP_JMPI: pc_q <= w_q[rs];
            `CIE_OP_ADD1, `CIE_OP_ADD2: begin
               if (fm == `CIE_FM_W)
                  w_q[rd] <= isum[15:0];
               else if (fm == `CIE_FM_DEFAULT_WORKING_REG)
                  w_q[`CIE_DEFAULT_WORKING_REG] <= isum[15:0];
               else
                  f_q <= isum[15:0];
               st_q[`CIE_S_C] <= isum[16];
               st_q[`CIE_S_DC] <= idc[4];
               st_q[`CIE_S_N] <= isum[15];
               st_q[`CIE_S_OV] <= ~isrc[15] & isum[15];
               st_q[`CIE_S_Z] <= (isum[15:0] == 16'h0000);
            end
            `CIE_OP_OR: begin
               if (fm == `CIE_FM_DEFAULT_WORKING_REG)
                  w_q[`CIE_DEFAULT_WORKING_REG] <= orv;
               else
                  f_q <= orv;
               st_q[`CIE_S_N] <= orv[15];
               st_q[`CIE_S_Z] <= (orv == 16'h0000);
            end
            default: st_q[`CIE_S_ERR] <= 1'b1;
         endcase
      end
   end
endmodule // cie_core

// >>> testbench/cie_core_sva.sv
// Purpose: Bus and command timing checks for cie_core.
// Assumes: Commands are written with all byte lanes enabled.
// Notes: Busy length is counted, too long for a repetition.
`timescale 1ns/1ps
module cie_core_sva (
   input wire CORE_CLK,
   input wire RSTN,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [7:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   input wire [31:0] WB_DAT_O,
   input wire WB_ACK_O,
   input wire BUSY
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   wire req = WB_CYC_I && WB_STB_I;
   wire [4:0] cop = WB_DAT_I[4:0];
   wire cmd_wr = req && WB_WE_I && WB_ACK_O && WB_ADR_I[7:2] == 6'h10 && !BUSY;
   wire cmd_go = cmd_wr && cop <= 5'h11;
   wire long_op = cop <= 5'h06 || cop == 5'h0d || cop == 5'h0e;
   reg [4:0] op_q;
   reg [5:0] len_q;
   wire [5:0] len_exp = op_q <= 5'h04 ? 6'h12 : (op_q == 5'h05 || op_q == 5'h06 || op_q == 5'h0d || op_q == 5'h0e) ?
      6'h02 : 6'h01;
   always @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         op_q <= 5'h00;
         len_q <= 6'h00;
      end else begin
         if (cmd_wr)
            op_q <= cop;
         len_q <= BUSY ? len_q + 6'h01 : 6'h00;
      end
   end
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
   ack_answer_a: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("request not answered");
   ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I)) else $error("ack without request");
   busy_start_a: assert property (cmd_go |=> BUSY) else $error("command did not start");
   quot_hold_a: assert property (cmd_go && cop <= 5'h04 |=> BUSY [*8]) else $error("quotient ended early");
   busy_len_a: assert property ($fell(BUSY) |-> len_q == len_exp) else $error("wrong busy length");
   one_cycle_a: assert property (cmd_wr && !long_op |=> BUSY ##1 !BUSY) else $error("op not one cycle");
   rdata_hold_a: assert property ($changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I) else $error("read data moved");
   cover property (cmd_go && cop == 5'h01);
   cover property ($fell(BUSY) && len_q == 6'h12);
   cover property (req && WB_WE_I && WB_ACK_O && BUSY);
endmodule // cie_core_sva

// >>> testbench/tb_cpu_insn_subset_exec.sv
// Purpose: Self-checking bench for cie_core.
// Assumes: Commands are issued only while the core is idle.
// Notes: Quotient, scan and add/OR expected values come from the small models below.
`timescale 1ns/1ps
`include "cie_defines.vh"
module tb_cpu_insn_subset_exec;
   reg CORE_CLK = 1'b0;
   reg RSTN = 1'b0;
   reg WB_CYC_I = 1'b0;
   reg WB_STB_I = 1'b0;
   reg WB_WE_I = 1'b0;
   reg [7:0] WB_ADR_I = 8'h00;
   reg [3:0] WB_SEL_I = 4'hf;
   reg [31:0] WB_DAT_I = 32'h0;
   wire [31:0] WB_DAT_O;
   wire WB_ACK_O;
   wire BUSY;
   integer failures = 0;
   integer n_tests = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] seed = 32'hc19ecb61;
   reg [31:0] rdat;
   reg [35:0] e;
   reg [15:0] v, w, h;
   reg [4:0] op;
   reg [1:0] fm;
   cie_core #(.DM_AW(4)) dut_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
      .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
      .WB_ACK_O(WB_ACK_O), .BUSY(BUSY));
   initial begin
      forever #25 CORE_CLK = ~CORE_CLK;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [35:0] dvm(input [4:0] o, input [15:0] lo, input [15:0] hi, input [15:0] dv);
      reg signed [33:0] n, d, q, r;
      reg ov;
      begin
         if (o == 5'h02) n = {18'h0, lo};
         else if (o == 5'h03) n = {2'h0, hi, lo};
         else if (o == 5'h01) n = {{2{hi[15]}}, hi, lo};
         else if (o == 5'h04) n = {{3{lo[15]}}, lo, 15'h0};
         else n = {{18{lo[15]}}, lo};
         d = o[1] ? {18'h0, dv} : {{18{dv[15]}}, dv};
         if (dv == 16'h0)
            d = 34'sd1;
         q = n / d;
         r = n % d;
         ov = dv == 16'h0 || (o[1] ? q > 34'sd65535 : (q > 34'sd32767 || q < -34'sd32768));
         dvm = {q[15], ov, q[15:0] == 16'h0, r != 34'sd0, r[15:0], q[15:0]};
      end
   endfunction
   function [16:0] scm(input [4:0] o, input [15:0] x);
      integer k;
      begin
         scm = (o == `CIE_OP_BCHG) ? 17'h1000f : 17'h10000;
         for (k = 0; k < 16; k = k + 1) begin
            if (o == `CIE_OP_BCHG && k < 15 && x[k] != x[15]) scm = 17'(14 - k);
            if (o == `CIE_OP_F1L && x[k]) scm = 17'(16 - k);
            if (o == `CIE_OP_F1R && x[15 - k]) scm = 17'(16 - k);
         end
      end
   endfunction
   function [20:0] adm(input [4:0] o, input [15:0] x, input [15:0] y);
      reg [16:0] s;
      reg dc;
      begin
         s = {1'b0, x} + ((o == `CIE_OP_ADD2) ? 17'h2 : 17'h1);
         dc = ({1'b0, x[3:0]} + ((o == `CIE_OP_ADD2) ? 5'h2 : 5'h1)) > 5'hf;
         adm = {dc, s[15], !x[15] & s[15], s[15:0] == 16'h0, s[16], s[15:0]};
         if (o == `CIE_OP_OR) begin
            s = {1'b0, x | y};
            adm = {1'b1, s[15], 1'b1, s[15:0] == 16'h0, 1'b1, s[15:0]};
         end
      end
   endfunction
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   always @(posedge CORE_CLK) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wb(input we, input [7:0] ad, input [31:0] d);
      begin
         WB_CYC_I <= 1'b1;
         WB_STB_I <= 1'b1;
         WB_WE_I <= we;
         WB_ADR_I <= ad;
         WB_DAT_I <= d;
         @(posedge CORE_CLK);
         while (WB_ACK_O !== 1'b1)
            @(posedge CORE_CLK);
         rdat = WB_DAT_O;
         WB_CYC_I <= 1'b0;
         WB_STB_I <= 1'b0;
         @(posedge CORE_CLK);
      end
   endtask
   task rchk(input [7:0] ad, input [31:0] m, input [31:0] x);
      begin
         wb(1'b0, ad, 32'h0);
         chk(rdat & m, x);
      end
   endtask
   // The W15 write lands while quotient ops are still busy and must be dropped
   task run(input [31:0] c);
      begin
         wb(1'b1, `CIE_A_CMD, c);
         wb(1'b1, 8'h3c, 32'hbeef);
         rdat = 32'h10000;
         while (rdat[16] !== 1'b0)
            wb(1'b0, `CIE_A_STAT, 32'h0);
      end
   endtask
   initial begin
      repeat (20) @(posedge CORE_CLK);
      RSTN <= 1'b1;
      @(posedge CORE_CLK);
      for (i = 0; i < 28; i = i + 1)
         rchk(8'(i * 4), 32'hffffffff, 32'h0);
      $display("test reset done");
      for (i = 0; i < 15; i = i + 1) begin
         seed = lfsr(seed);
         op = 5'(i % 5);
         v = (i == 2) ? 16'h0007 : seed[15:0];
         w = (i == 2) ? 16'h0002 : (i == 3) ? 16'h0000 : seed[31:16];
         h = (i > 9) ? 16'h0 : seed[23:8];
         wb(1'b1, 8'h08, {16'h0, v});
         wb(1'b1, 8'h0c, {16'h0, h});
         wb(1'b1, 8'h10, {16'h0, w});
         wb(1'b1, 8'h3c, 32'h0);
         run({19'h0, 4'h4, 4'h2, op});
         e = dvm(op, v, h, w);
         rchk(8'h00, 32'hffff, {16'h0, e[15:0]});
         rchk(8'h04, 32'hffff, {16'h0, e[31:16]});
         rchk(`CIE_A_STAT, 32'hf, {28'h0, e[35:32]});
         rchk(8'h3c, 32'hffff, 32'h0);
      end
      $display("test quotient done");
      for (i = 0; i < 12; i = i + 1) begin
         seed = lfsr(seed);
         op = `CIE_OP_BCHG + 5'(i % 3);
         v = (i < 3) ? 16'h0000 : (i < 6) ? {i[0], 15'h1} : seed[15:0];
         wb(1'b1, 8'h18, {16'h0, v});
         wb(1'b1, `CIE_A_STAT, 32'h1e);
         run({19'h0, 4'h7, 4'h6, op});
         e = {19'h0, scm(op, v)};
         rchk(8'h1c, 32'hffff, {16'h0, e[15:0]});
         rchk(`CIE_A_STAT, 32'h1f, {27'h0f, e[16]});
         run({19'h0, 4'h7, 4'h6, `CIE_OP_SWAP});
         rchk(8'h18, 32'hffff, {16'h0, e[15:0]});
         rchk(8'h1c, 32'hffff, {16'h0, v});
         rchk(`CIE_A_STAT, 32'h1f, {27'h0f, e[16]});
      end
      $display("test scan and swap done");
      for (i = 0; i < 12; i = i + 1) begin
         seed = lfsr(seed);
         op = `CIE_OP_ADD1 + 5'(i % 3);
         fm = 2'((i / 3) % 3);
         v = (i == 0) ? 16'hffff : (i == 1) ? 16'h7fff : (i == 2) ? 16'h000f : seed[15:0];
         w = seed[31:16];
         wb(1'b1, 8'h18, {16'h0, v});
         wb(1'b1, `CIE_A_FREG, {16'h0, v});
         wb(1'b1, 8'h00, {16'h0, w});
         wb(1'b1, `CIE_A_STAT, 32'h15);
         run({6'h0, fm, 11'h0, 4'h7, 4'h6, op});
         e = {15'h0, adm(op, v, w)};
         h = (fm == 2'h2) ? 16'h0 : (fm == 2'h1 || op == `CIE_OP_OR) ? {8'h0, `CIE_A_FREG} : 16'h1c;
         rchk(h[7:0], 32'hffff, {16'h0, e[15:0]});
         rchk(`CIE_A_STAT, 32'h1f, {27'h0, e[20:16]});
      end
      $display("test add and or done");
      wb(1'b0, `CIE_A_PC, 32'h0);
      w = rdat[15:0];
      seed = lfsr(seed);
      wb(1'b1, `CIE_A_ARG, {seed[31:16], 2'h0, seed[13:0]});
      run({27'h0, `CIE_OP_LOOPL});
      rchk(`CIE_A_LCNT, 32'h3fff, {18'h0, seed[13:0]});
      rchk(`CIE_A_LEND, 32'hffff, {16'h0, w + seed[31:16]});
      rchk(`CIE_A_PC, 32'hffff, {16'h0, w + 16'h2});
      wb(1'b1, 8'h00, {16'h0, ~seed[15:0]});
      run({27'h0, `CIE_OP_LOOPW});
      rchk(`CIE_A_LCNT, 32'hffff, {16'h0, ~seed[15:0]});
      rchk(`CIE_A_LEND, 32'hffff, {16'h0, w + 16'h2 + seed[31:16]});
      rchk(`CIE_A_PC, 32'hffff, {16'h0, w + 16'h4});
      run({27'h0, `CIE_OP_JMPD});
      rchk(`CIE_A_PC, 32'hffff, {16'h0, seed[31:16]});
      run({27'h0, `CIE_OP_JMPI});
      rchk(`CIE_A_PC, 32'hffff, {16'h0, ~seed[15:0]});
      $display("test loop and jump done");
      wb(1'b1, 8'h84, 32'h1234);
      wb(1'b1, 8'h88, 32'h0234);
      wb(1'b1, 8'h10, 32'h4000);
      wb(1'b1, 8'h1c, 32'h8000);
      wb(1'b1, 8'h20, 32'h2);
      wb(1'b1, 8'h2c, 32'h4);
      run(32'h00640007);
      rchk(8'h14, 32'hffff, 32'h1000);
      rchk(8'h20, 32'hffff, 32'h8);
      rchk(8'h2c, 32'hffff, 32'h6);
      rchk(`CIE_A_ACAL, 32'hffffffff, 32'h20000000);
      run(32'h003fc008);
      rchk(`CIE_A_ACAL, 32'hffffffff, 32'h40000000);
      run(32'h003fe087);
      rchk(`CIE_A_ACBL, 32'hffffffff, 32'h08000000);
      run(32'h003fe068);
      rchk(`CIE_A_ACBL, 32'hffffffff, 32'h88000000);
      rchk(`CIE_A_STAT, 32'h200, 32'h200);
      // Indexed X fetch from W9+W12, Y from W10 stepping down by six
      wb(1'b1, 8'h8c, 32'h0500);
      wb(1'b1, 8'h24, 32'h2);
      wb(1'b1, 8'h28, 32'h4);
      wb(1'b1, 8'h30, 32'h4);
      run(32'h00938007);
      rchk(8'h18, 32'hffff, 32'h02cc);
      rchk(8'h24, 32'hffff, 32'h2);
      rchk(8'h28, 32'hffff, 32'hfffe);
      wb(1'b1, `CIE_A_STAT, 32'h0);
      run(32'h12);
      rchk(`CIE_A_STAT, 32'h4000, 32'h4000);
      $display("test distance and refusal done");
      tally_and_finish;
   end
endmodule // tb_cpu_insn_subset_exec
bind cie_core cie_core_sva chk_u (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .BUSY(BUSY));
